// ### logic/vic_vector_pkg.sv
// Constants, field layouts and carrier types for the vector address logic.
// Assumes one system clock; the raw, enable and select registers live
// outside and reach this block as per-source state vectors.
package vic_vector_pkg;

  localparam int unsigned NUM_SLOTS  = 16;
  localparam int unsigned NUM_SRC    = 32;
  localparam int unsigned NUM_EVENTS = 4;

  // Byte addresses on the register bus.
  localparam logic [31:0] ADDR_PROTECTION     = 32'hFFFFF020;
  localparam logic [31:0] ADDR_VECTOR_PORT    = 32'hFFFFF030;
  localparam logic [31:0] ADDR_DEFAULT_VECTOR = 32'hFFFFF034;
  localparam logic [31:0] ADDR_EVENT_STATUS   = 32'hFFFFF040;
  localparam logic [31:0] ADDR_EVENT_MASK     = 32'hFFFFF044;
  localparam logic [31:0] ADDR_SLOT_ADDR_BASE = 32'hFFFFF100;
  localparam logic [31:0] ADDR_SLOT_CTRL_BASE = 32'hFFFFF200;

  // Slot control field positions.
  localparam int unsigned CTRL_ENABLE_BIT = 5;
  localparam int unsigned CTRL_SRC_MSB    = 4;
  localparam int unsigned CTRL_SRC_LSB    = 0;

  // Reset values.
  localparam logic        RST_PROTECTION     = 1'h0;
  localparam logic [31:0] RST_DEFAULT_VECTOR = 32'h0;
  localparam logic [31:0] RST_SLOT_ADDR      = 32'h0;
  localparam logic [5:0]  RST_SLOT_CTRL      = 6'h00;
  localparam logic [3:0]  RST_EVENT_MASK     = 4'h0;

  // Source channel numbers.
  localparam int unsigned CH_WATCHDOG  = 0;
  localparam int unsigned CH_SOFT_ONLY = 1;
  localparam int unsigned CH_DBG_RX    = 2;
  localparam int unsigned CH_DBG_TX    = 3;
  localparam int unsigned CH_TIMER0    = 4;
  localparam int unsigned CH_TIMER1    = 5;
  localparam int unsigned CH_UART0     = 6;
  localparam int unsigned CH_UART1     = 7;
  localparam int unsigned CH_PWM       = 8;
  localparam int unsigned CH_I2C       = 9;
  localparam int unsigned CH_SPI       = 10;
  localparam int unsigned CH_PLL       = 12;
  localparam int unsigned CH_RTC       = 13;
  localparam int unsigned CH_EXT0      = 14;
  localparam int unsigned CH_EXT1      = 15;
  localparam int unsigned CH_EXT2      = 16;

  // Event status bit positions.
  localparam int unsigned EV_VEC_FETCH   = 0;
  localparam int unsigned EV_DEF_FETCH   = 1;
  localparam int unsigned EV_SERVICE_END = 2;
  localparam int unsigned EV_DENIED      = 3;

  typedef struct packed {
    logic       enable;
    logic [4:0] source;
  } slot_ctrl_t;

  typedef struct packed {
    logic [31:0] asserted;
    logic [31:0] enabled;
    logic [31:0] category_select;
  } src_state_t;

  typedef struct packed {
    logic       watchdog_event;
    logic       dbg_rx;
    logic       dbg_tx;
    logic [3:0] timer0_match;
    logic [3:0] timer0_capture;
    logic       timer1_line;
    logic       uart0_line;
    logic       uart1_line;
    logic       modem_status_event;
    logic [6:0] pwm_match;
    logic [3:0] pwm_capture;
    logic       i2c_line;
    logic       spi_line;
    logic       pll_line;
    logic       counter_increment_flag;
    logic       alarm_flag;
    logic       external_line_zero;
    logic       external_line_one;
    logic       external_line_two;
  } periph_lines_t;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_HOLD = 1'b1
  } bus_state_t;

endpackage

// ### logic/vic_vector_addr.sv
// Vector address, priority resolution and source channel assembly.
// Assumes an APB master on clk; peripheral lines arrive already on clk.
`timescale 1ns/1ns

// Summary of operation
// - Sixteen 32-bit read/write slot address registers, one per vectored slot.
// - Vector port read returns address of highest-priority qualifying slot.
// - With no qualifying slot, vector port read returns default address.
// - Vector port write stores nothing; it updates priority state and sets the service-end event flag.
// - Vector port and default address register reset to zero.
// - Protection bit set restricts register access to privileged mode.
// - Each peripheral drives one combined line into its channel.
// - One channel has no hardware request; software interrupts only.
// - First timer match and capture line drives channel 4.
// - Second serial port line, with modem status, drives channel 7.
// - Modulator seven match and four capture events drive channel 8.
// - Clock counter-increment and alarm flags drive channel 13.
// - External line zero drives channel 14, external line two 16.
// - Slot 0 has highest priority, slot 15 lowest.
// - Slot control: enable in bit 5, source in bits 4:0, reset zero.
// - Same source in several enabled slots: lower slot wins.
// - Only sources with select bit 0 (IRQ) take part.
module vic_vector_addr (
  // Clock and reset.
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  // APB slave.
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [31:0]                   paddr,
  input  wire logic [31:0]                   pwdata,
  input  wire logic [2:0]                    pprot,
  output logic                               pready,
  output logic [31:0]                        prdata,
  output logic                               pslverr,
  // Source state from the adjacent raw, enable and select registers.
  input  wire vic_vector_pkg::src_state_t    src_state,
  // Peripheral interrupt lines.
  input  wire vic_vector_pkg::periph_lines_t periph,
  // Assembled hardware request per source channel.
  output logic [31:0]                        channel_request,
  // Event interrupt.
  output logic                               intr_out
);
  import vic_vector_pkg::*;

  // Lowest set bit of a 17-bit vector as a one-hot mask.
  function automatic logic [16:0] lowest_onehot(input logic [16:0] v);
    lowest_onehot = v & (~v + 17'h00001);
  endfunction

  bus_state_t         state_r;
  bus_state_t         state_nxt;
  logic               prot_r;
  logic [31:0]        default_r;
  logic [31:0]        slot_addr_r [NUM_SLOTS];
  slot_ctrl_t         slot_ctrl_r [NUM_SLOTS];
  logic [16:0]        in_service_r;
  logic [16:0]        in_service_nxt;
  logic [15:0]        win_r;
  logic               win_valid_r;
  logic               denied_r;
  logic [31:0]        prdata_r;
  logic               pslverr_r;
  logic [3:0]         status_r;
  logic [3:0]         status_nxt;
  logic [3:0]         mask_r;
  logic [31:0]        chan_req_r;
  logic [31:0]        chan_req_nxt;

  // Bus phase decode: capture on the first access edge, finish on the next.
  wire         capture   = psel & penable & (state_r == BUS_IDLE);
  wire         complete  = psel & penable & (state_r == BUS_HOLD);
  wire         denied    = prot_r & ~pprot[0];
  wire [3:0]   slot_idx  = paddr[5:2];
  wire         sel_prot  = (paddr == ADDR_PROTECTION);
  wire         sel_vec   = (paddr == ADDR_VECTOR_PORT);
  wire         sel_def   = (paddr == ADDR_DEFAULT_VECTOR);
  wire         sel_stat  = (paddr == ADDR_EVENT_STATUS);
  wire         sel_mask  = (paddr == ADDR_EVENT_MASK);
  wire         sel_saddr = (paddr[31:6] == ADDR_SLOT_ADDR_BASE[31:6])
                           & (paddr[1:0] == 2'h0);
  wire         sel_sctrl = (paddr[31:6] == ADDR_SLOT_CTRL_BASE[31:6])
                           & (paddr[1:0] == 2'h0);
  wire         mapped    = sel_prot | sel_vec | sel_def | sel_stat
                           | sel_mask | sel_saddr | sel_sctrl;
  wire         wr_ok     = complete & pwrite & ~denied;
  wire         rd_vec    = complete & ~pwrite & ~denied_r & sel_vec;
  wire         wr_vec    = wr_ok & sel_vec;

  // Qualifying IRQ sources and per-slot eligibility.
  wire [31:0]  src_irq   = src_state.asserted & src_state.enabled
                           & ~src_state.category_select;
  logic [15:0] slot_hit;
  logic [15:0] svc_block;
  logic [15:0] eligible;
  logic [31:0] vec_chain [NUM_SLOTS+1];
  logic [16:0] win17;
  logic [31:0] vec_value;
  logic [31:0] rd_value;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SLOTS; gi = gi + 1) begin : g_slot
      // A slot qualifies when enabled and its source is an active IRQ.
      assign slot_hit[gi] = slot_ctrl_r[gi].enable
                            & src_irq[slot_ctrl_r[gi].source];
      // Slots at or below an in-service level are held off.
      assign svc_block[gi] = |in_service_r[gi:0];
      assign eligible[gi]  = slot_hit[gi] & ~svc_block[gi];
      assign vec_chain[gi+1] = vec_chain[gi]
                               | (win17[gi] ? slot_addr_r[gi] : 32'h0);

      // Slot address and control registers.
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          slot_addr_r[gi] <= RST_SLOT_ADDR;
          slot_ctrl_r[gi] <= RST_SLOT_CTRL;
        end else if (wr_ok && slot_idx == 4'(gi)) begin
          if (sel_saddr) begin
            slot_addr_r[gi] <= pwdata;
          end
          if (sel_sctrl) begin
            slot_ctrl_r[gi] <= pwdata[CTRL_ENABLE_BIT:CTRL_SRC_LSB];
          end
        end
      end
    end
  endgenerate

  // Lowest eligible slot index wins; slot 0 ranks highest.
  assign vec_chain[0] = 32'h0;
  assign win17        = lowest_onehot({1'b0, eligible});
  assign vec_value    = (|eligible) ? vec_chain[NUM_SLOTS]
                                    : default_r;

  // Read data selection; denied or unmapped reads give zero.
  always_comb begin
    rd_value = 32'h0;
    if (denied) begin
      rd_value = 32'h0;
    end else if (sel_prot) begin
      rd_value = {31'h0, prot_r};
    end else if (sel_vec) begin
      rd_value = vec_value;
    end else if (sel_def) begin
      rd_value = default_r;
    end else if (sel_stat) begin
      rd_value = {28'h0, status_r};
    end else if (sel_mask) begin
      rd_value = {28'h0, mask_r};
    end else if (sel_saddr) begin
      rd_value = slot_addr_r[slot_idx];
    end else if (sel_sctrl) begin
      rd_value = {26'h0, slot_ctrl_r[slot_idx]};
    end
  end

  // Bus state: one wait state before pready.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      BUS_IDLE: begin
        if (capture) begin
          state_nxt = BUS_HOLD;
        end
      end
      BUS_HOLD: begin
        state_nxt = BUS_IDLE;
      end
    endcase
  end

  // Priority state: a vector read enters a level, a vector write leaves it.
  always_comb begin
    in_service_nxt = in_service_r;
    if (rd_vec) begin
      in_service_nxt = in_service_r
                       | (win_valid_r ? {1'b0, win_r} : 17'h10000);
    end else if (wr_vec) begin
      in_service_nxt = in_service_r & ~lowest_onehot(in_service_r);
    end
  end

  // Event flags: set wins over a write-one clear in the same cycle.
  wire [3:0] ev_set = {complete & denied,
                       wr_vec,
                       rd_vec & ~win_valid_r,
                       rd_vec & win_valid_r};
  wire [3:0] ev_clr = (wr_ok & sel_stat) ? pwdata[3:0] : 4'h0;
  assign status_nxt = (status_r & ~ev_clr) | ev_set;

  // Channel assembly: one combined line per peripheral.
  always_comb begin
    chan_req_nxt               = 32'h0;
    chan_req_nxt[CH_WATCHDOG]  = periph.watchdog_event;
    chan_req_nxt[CH_SOFT_ONLY] = 1'b0;
    chan_req_nxt[CH_DBG_RX]    = periph.dbg_rx;
    chan_req_nxt[CH_DBG_TX]    = periph.dbg_tx;
    chan_req_nxt[CH_TIMER0]    = |{periph.timer0_match,
                                   periph.timer0_capture};
    chan_req_nxt[CH_TIMER1]    = periph.timer1_line;
    chan_req_nxt[CH_UART0]     = periph.uart0_line;
    chan_req_nxt[CH_UART1]     = periph.uart1_line
                                 | periph.modem_status_event;
    chan_req_nxt[CH_PWM]       = |{periph.pwm_match,
                                   periph.pwm_capture};
    chan_req_nxt[CH_I2C]       = periph.i2c_line;
    chan_req_nxt[CH_SPI]       = periph.spi_line;
    chan_req_nxt[CH_PLL]       = periph.pll_line;
    chan_req_nxt[CH_RTC]       = periph.counter_increment_flag
                                 | periph.alarm_flag;
    chan_req_nxt[CH_EXT0]      = periph.external_line_zero;
    chan_req_nxt[CH_EXT1]      = periph.external_line_one;
    chan_req_nxt[CH_EXT2]      = periph.external_line_two;
  end

  // Bus capture registers and priority state.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r      <= BUS_IDLE;
      prdata_r     <= 32'h0;
      pslverr_r    <= 1'b0;
      win_r        <= 16'h0;
      win_valid_r  <= 1'b0;
      denied_r     <= 1'b0;
      in_service_r <= 17'h0;
    end else begin
      state_r      <= state_nxt;
      in_service_r <= in_service_nxt;
      if (capture) begin
        prdata_r    <= pwrite ? 32'h0 : rd_value;
        pslverr_r   <= ~mapped;
        win_r       <= win17[15:0];
        win_valid_r <= |eligible;
        denied_r    <= denied;
      end
    end
  end

  // Software-visible control registers.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prot_r    <= RST_PROTECTION;
      default_r <= RST_DEFAULT_VECTOR;
      mask_r    <= RST_EVENT_MASK;
      status_r  <= 4'h0;
    end else begin
      status_r <= status_nxt;
      if (wr_ok && sel_prot) begin
        prot_r <= pwdata[0];
      end
      if (wr_ok && sel_def) begin
        default_r <= pwdata;
      end
      if (wr_ok && sel_mask) begin
        mask_r <= pwdata[3:0];
      end
    end
  end

  // Registered channel requests.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      chan_req_r <= 32'h0;
    end else begin
      chan_req_r <= chan_req_nxt;
    end
  end

  // Outputs.
  assign pready          = (state_r == BUS_HOLD);
  assign prdata          = prdata_r;
  assign pslverr         = pready & pslverr_r;
  assign channel_request = chan_req_r;
  assign intr_out        = |(status_r & mask_r);

  // Checks.
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_bus_wait_one: assert property (capture |=> pready ##1 !pready)
    else $error("pready not one cycle after access start");
  a_vec_slot_read: assert property (
    capture && !pwrite && sel_vec && !denied && (|eligible)
    |=> prdata == $past(vec_chain[NUM_SLOTS]))
    else $error("vector read did not return winning slot address");
  a_vec_default_read: assert property (
    capture && !pwrite && sel_vec && !denied && !(|eligible)
    |=> prdata == $past(default_r))
    else $error("vector read did not return default address");
  a_vec_write_nostore: assert property (
    wr_vec |=> default_r == $past(default_r)
               && ($countones(in_service_r)
                   < $countones($past(in_service_r))
                   || $past(in_service_r) == 17'h0))
    else $error("vector write stored data or left priority state");
  a_slot0_top: assert property (
    capture && sel_vec && !denied && eligible[0] |=> win_r == 16'h0001)
    else $error("slot 0 did not win");
  a_denied_zero: assert property (
    capture && denied |=> prdata == 32'h0)
    else $error("denied read returned data");
  a_denied_nowrite: assert property (
    complete && pwrite && denied
    |=> $stable(prot_r) && $stable(default_r) && $stable(mask_r))
    else $error("denied write changed state");
  a_slot_write: assert property (
    wr_ok && sel_saddr |=> slot_addr_r[$past(slot_idx)] == $past(pwdata))
    else $error("slot address write lost");
  a_soft_channel: assert property (
    channel_request[CH_SOFT_ONLY] == 1'b0)
    else $error("software-only channel driven by hardware");
  a_pwm_channel: assert property (
    (|{periph.pwm_match, periph.pwm_capture}) |=> channel_request[CH_PWM])
    else $error("modulator line not on its channel");
  a_sticky_hold: assert property (
    status_r[EV_SERVICE_END] && !(wr_ok && sel_stat)
    |=> status_r[EV_SERVICE_END])
    else $error("sticky event flag dropped without clear");
  // Priority level bookkeeping, category exclusion, register writes, events and error response.
  a_vec_enter: assert property (
    rd_vec && win_valid_r |=> (in_service_r[15:0] & $past(win_r)) != 16'h0)
    else $error("vector read did not enter the winning level");
  a_default_level: assert property (
    rd_vec && !win_valid_r |=> in_service_r[16])
    else $error("default read did not enter the default level");
  a_top_level_block: assert property (
    in_service_r[0] |-> eligible == 16'h0)
    else $error("slot eligible while slot 0 is in service");
  a_category_out: assert property (
    src_state.category_select[slot_ctrl_r[0].source] |-> !slot_hit[0])
    else $error("fast category source reached a vectored slot");
  a_slot_ctrl_write: assert property (
    wr_ok && sel_sctrl
    |=> slot_ctrl_r[$past(slot_idx)] == $past(pwdata[5:0]))
    else $error("slot control write lost");
  a_prot_write: assert property (
    wr_ok && sel_prot |=> prot_r == $past(pwdata[0]))
    else $error("protection write lost");
  a_default_write: assert property (
    wr_ok && sel_def |=> default_r == $past(pwdata))
    else $error("default address write lost");
  a_denied_event: assert property (
    complete && denied |=> status_r[EV_DENIED])
    else $error("denied access did not raise its event");
  a_unmapped_err: assert property (
    complete && !mapped |-> pslverr)
    else $error("unmapped access answered without error");
  a_intr_level: assert property (
    status_r[EV_DENIED] && mask_r[EV_DENIED] |-> intr_out)
    else $error("unmasked event did not raise the interrupt");

  // Channel checks: a combined line shows one cycle after its source.
  a_chan_timer0: assert property (
    (|{periph.timer0_match, periph.timer0_capture})
    |=> channel_request[CH_TIMER0])
    else $error("first timer line not on its channel");
  a_chan_uart1: assert property (
    periph.uart1_line || periph.modem_status_event
    |=> channel_request[CH_UART1])
    else $error("second serial line not on its channel");
  a_chan_rtc: assert property (
    periph.counter_increment_flag || periph.alarm_flag
    |=> channel_request[CH_RTC])
    else $error("clock flags not on their channel");
  a_chan_ext0: assert property (
    periph.external_line_zero |=> channel_request[CH_EXT0])
    else $error("external line zero not on its channel");
  a_chan_ext2: assert property (
    periph.external_line_two |=> channel_request[CH_EXT2])
    else $error("external line two not on its channel");
  a_chan_unused: assert property (
    !channel_request[11] && channel_request[31:17] == 15'h0000)
    else $error("unassigned channel driven");

  c_vec_read: cover property (rd_vec && win_valid_r);
  c_def_read: cover property (rd_vec && !win_valid_r);
  c_service_end: cover property (wr_vec ##1 intr_out);
  c_denied: cover property (complete && denied);
  c_unmapped: cover property (complete && pslverr);

endmodule // vic_vector_addr

// ### tb/cpu_model.sv
// Processor core model: an APB master that runs register cycles.
// Assumes an APB slave on clk that answers with pready.
`timescale 1ns/1ns
module cpu_model
  import vic_vector_pkg::*;
(
  // Clock.
  input  wire logic        clk,
  // APB master side.
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [31:0]      paddr,
  output logic [31:0]      pwdata,
  output logic [2:0]       pprot,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  logic [31:0] dq;
  logic        de;

  // The bus is idle at time zero.
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pprot} = '0;
  end

  // One transfer, held until pready is sampled high, then released.
  task automatic xfer(input logic w, input logic [31:0] a, d,
                      input logic pv, output logic [31:0] q,
                      output logic e);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pprot   <= {2'h0, pv};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a; // Released lines do not keep the last value.
    pwdata  <= ~d;
  endtask

  // End of a service routine writes the vector port.
  task automatic isr_end();
    xfer(1'b1, ADDR_VECTOR_PORT, 32'h0, 1'b1, dq, de);
  endtask
endmodule // cpu_model

// ### tb/vectored_irq_address_logic_test.sv
// Self-checking bench for the vector address logic.
// Assumes the core model drives the APB and the bench the source lines.
`timescale 1ns/1ns
module vectored_irq_address_logic_test;
  import vic_vector_pkg::*;
  logic          clk = 1'b0;
  logic          sys_rst = 1'b1;
  logic          psel, penable, pwrite, pready, pslverr, intr_out, err;
  logic [31:0]   paddr, pwdata, prdata, channel_request, q;
  logic [2:0]    pprot;
  src_state_t    src_state = '0;
  periph_lines_t periph = '0;
  periph_lines_t p;
  int            failures = 0;
  int            n_checks = 0;
  int            cyc = 0;

  // Clock at 125 MHz.
  always #4 clk = ~clk;

  vic_vector_addr dut_u (.clk(clk), .sys_rst(sys_rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pprot(pprot), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .src_state(src_state), .periph(periph),
    .channel_request(channel_request), .intr_out(intr_out));

  cpu_model cpu_u (.clk(clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pprot(pprot),
    .pready(pready), .prdata(prdata), .pslverr(pslverr));

  // Compares one value and counts it.
  task automatic chk(input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Register cycles; privileged unless told otherwise.
  task automatic wr(input logic [31:0] a, d, input logic pv = 1'b1);
    cpu_u.xfer(1'b1, a, d, pv, q, err);
  endtask
  task automatic rd(input logic [31:0] a, input logic pv = 1'b1);
    cpu_u.xfer(1'b0, a, 32'h0, pv, q, err);
  endtask

  // Reads the vector, compares it and ends the service.
  task automatic vec(input logic [31:0] exp);
    rd(ADDR_VECTOR_PORT);
    chk(q, exp);
    cpu_u.isr_end();
  endtask

  // Waits for the interrupt level to settle, then compares it.
  task automatic irq(input logic exp);
    repeat (2) @(posedge clk);
    #1 chk({31'h0, intr_out}, {31'h0, exp});
  endtask

  // Values straight after reset.
  task automatic t_reset();
    rd(ADDR_PROTECTION);
    chk(q, 32'h0);
    rd(ADDR_DEFAULT_VECTOR);
    chk(q, 32'h0);
    rd(ADDR_SLOT_CTRL_BASE + 32'h3C);
    chk(q, 32'h0);
    vec(32'h0);
    $display("test reset done");
  endtask

  // Every slot address register is written and read back.
  task automatic t_slots();
    for (int i = 0; i < 16; i++)
      wr(ADDR_SLOT_ADDR_BASE + 32'(4 * i), 32'hA0000000 + 32'(16 * i));
    for (int i = 0; i < 16; i++) begin
      rd(ADDR_SLOT_ADDR_BASE + 32'(4 * i));
      chk(q, 32'hA0000000 + 32'(16 * i));
    end
    $display("test slots done");
  endtask

  // Priority, duplicates, disabled slots and category exclusion.
  task automatic t_vector();
    wr(ADDR_DEFAULT_VECTOR, 32'hDEF00000);
    wr(ADDR_SLOT_CTRL_BASE, 32'h26);
    wr(ADDR_SLOT_CTRL_BASE + 32'h4, 32'h2A);
    wr(ADDR_SLOT_CTRL_BASE + 32'h8, 32'h26);
    wr(ADDR_SLOT_CTRL_BASE + 32'h38, 32'h0C);
    wr(ADDR_SLOT_CTRL_BASE + 32'h3C, 32'h29);
    rd(ADDR_SLOT_CTRL_BASE + 32'h4);
    chk(q, 32'h2A);
    src_state <= '{asserted: 32'h640, enabled: '1, category_select: '0};
    wr(ADDR_VECTOR_PORT, 32'h5A5A5A5A);
    vec(32'hA0000000);
    src_state.asserted <= 32'h600;
    vec(32'hA0000010);
    src_state.asserted <= 32'h200;
    vec(32'hA00000F0);
    src_state.asserted <= 32'h1000;
    vec(32'hDEF00000);
    src_state <= '{asserted: 32'h40, enabled: '1, category_select: 32'h40};
    vec(32'hDEF00000);
    src_state <= '0;
    $display("test vector done");
  endtask

  // Protection, denied access event, mask and unmapped address.
  task automatic t_protect();
    wr(ADDR_EVENT_STATUS, 32'hF);
    wr(ADDR_EVENT_MASK, 32'h8);
    irq(1'b0);
    wr(ADDR_PROTECTION, 32'h1);
    wr(ADDR_DEFAULT_VECTOR, 32'h55555555, 1'b0);
    chk({31'h0, err}, 32'h0);
    rd(ADDR_DEFAULT_VECTOR, 1'b0);
    chk(q, 32'h0);
    rd(ADDR_DEFAULT_VECTOR);
    chk(q, 32'hDEF00000);
    irq(1'b1);
    wr(ADDR_EVENT_STATUS, 32'h8);
    irq(1'b0);
    wr(ADDR_PROTECTION, 32'h0);
    wr(ADDR_DEFAULT_VECTOR, 32'h13572468, 1'b0);
    rd(ADDR_DEFAULT_VECTOR, 1'b0);
    chk(q, 32'h13572468);
    rd(32'hFFFFF0F0);
    chk({31'h0, err}, 32'h1);
    chk(q, 32'h0);
    $display("test protect done");
  endtask

  // Drives one set of peripheral flags and compares the channels.
  task automatic chan(input periph_lines_t v, input logic [31:0] exp);
    @(posedge clk);
    periph <= v;
    repeat (2) @(posedge clk);
    #1 chk(channel_request, exp);
  endtask

  // Peripheral lines land on their channels.
  task automatic t_channels();
    p = '0; p.watchdog_event = 1'b1;
    chan(p, 32'h1);
    p = '0; p.timer0_capture = 4'h8;
    chan(p, 32'h10);
    p = '0; p.timer0_match = 4'h1;
    chan(p, 32'h10);
    p = '0; p.modem_status_event = 1'b1;
    chan(p, 32'h80);
    p = '0; p.pwm_match = 7'h40;
    chan(p, 32'h100);
    p = '0; p.pwm_capture = 4'h8;
    chan(p, 32'h100);
    p = '0; p.alarm_flag = 1'b1;
    chan(p, 32'h2000);
    p = '0; p.counter_increment_flag = 1'b1;
    chan(p, 32'h2000);
    p = '0; p.external_line_zero = 1'b1;
    chan(p, 32'h4000);
    p = '0; p.external_line_two = 1'b1;
    chan(p, 32'h10000);
    chan('1, 32'h0001F7FD);
    $display("test channels done");
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("checks=%0d failures=%0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // A hang is cut short after a fixed number of cycles.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      conclude();
    end
  end

  // Main sequence.
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset();
    t_slots();
    t_vector();
    t_protect();
    t_channels();
    conclude();
  end
endmodule // vectored_irq_address_logic_test
